// File: scsi_cfg_cmd.sv
/*
  Adapter configuration and format command interpreter behind an AXI4-Lite
  register slave: pacing, feature control, format interlock, format unit
  dispatch, inquiry header assembly and per-device command time-out.
  Assumes dev_busy comes from logic on the same clock, and that the format
  request and cache flush pulses are consumed by the SCSI side.
*/
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
// Notes on behaviour
// - inquiry header bytes, byte four equals N-4
// - pacing goes to device 15, 25 to 100
// - accepted pacing value persists until replaced
// - reset sets pacing to full bandwidth
// - time-out seconds in second word bits 12-0
// - zero time-out limit never expires
// - time-out limit resets to 45 seconds
// - bits 15-13 select maximum synchronous rate
// - adapter-wide feature sets rate and all time-outs
// - per-device feature ignores rate, sets one time-out
// - format needs prepare immediately before, else error
// - format discards the device's cached data
// - interleave 0 default, 1 sequential, forwarded
// - defect list fetched from buffer when supplied
// - only block-format defect list accepted
`timescale 1ns/100ps
`default_nettype none

module scsi_cfg_cmd #(
  parameter int unsigned SEC_CYCLES = scsi_cfg_pkg::SEC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  input wire logic [14:0] dev_busy,
  output logic [14:0] cmd_expire,
  output logic [6:0] pace_pct,
  output logic dma_slot_en,
  output logic [2:0] rate_sel,
  output scsi_cfg_pkg::fmt_req_t fmt_req,
  output scsi_cfg_pkg::cache_flush_t cache_flush
);

  // prescaler is PRESC_W bits wide, so larger periods cannot be counted
  if (SEC_CYCLES < 1 || SEC_CYCLES >= (1 << scsi_cfg_pkg::PRESC_W))
  begin : g_bad_sec_cycles
    $error("SEC_CYCLES out of range");
  end

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [11:0] cmd;
    logic [15:0] arg;
    logic [31:0] fmt_mod;
    logic [31:0] fmt_addr;
    logic [31:0] fmt_count;
    logic [3:0] res_dev;
    logic [3:0] res_status;
    logic [7:0] res_err;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [6:0] pace;
    logic [7:0] pace_acc;
    logic dma_slot;
    logic [2:0] rate;
    logic armed;
    logic [3:0] prep_dev;
    logic [31:0] inq_src;
    logic [14:0][12:0] lim;
    logic [14:0][12:0] cnt;
    logic [24:0] presc;
    logic [14:0] expire;
    scsi_cfg_pkg::fmt_req_t fmt;
    scsi_cfg_pkg::cache_flush_t flush;
  } state_t;

  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.pace = scsi_cfg_pkg::PACE_FULL;
    r.rate = scsi_cfg_pkg::RATE_DEFAULT;
    for (int i = 0; i < scsi_cfg_pkg::NDEV; i++)
      r.lim[i] = scsi_cfg_pkg::TMO_DEFAULT;
    return r;
  endfunction : reset_state

  localparam state_t RST_STATE = reset_state();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        m[b*8 +: 8] = d[b*8 +: 8];
    return m;
  endfunction : merge

  state_t s_reg;
  state_t s_next;
  logic wr_do;
  logic exec;
  logic exec_ok;
  logic tick;
  logic [7:0] op;
  logic [3:0] cdev;
  logic [31:0] wd;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] ev;
  logic [7:0] inq_len;
  logic [14:0] zero_lim;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.fmt.start = 1'b0;
    s_next.flush.valid = 1'b0;
    s_next.expire = '0;
    ev = '0;
    wd = merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
    op = wd[7:0];
    cdev = wd[scsi_cfg_pkg::CMD_DEV_LSB +: 4];
    inq_len = s_reg.inq_src[31:24] - scsi_cfg_pkg::INQ_FIXED_LEN;
    wr_do = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
    exec = wr_do && ({s_reg.aw_addr[7:2], 2'b00} == scsi_cfg_pkg::OFF_CMD);
    exec_ok = 1'b0;
    tick = (s_reg.presc == 25'(SEC_CYCLES - 1));
    zero_lim = '0;
    // bus write side: address and data taken in either order
    if (awvalid && !s_reg.aw_held)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && !s_reg.w_held)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (wr_do)
    begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      unique case ({s_reg.aw_addr[7:2], 2'b00})
        scsi_cfg_pkg::OFF_ARG: s_next.arg = 16'(merge({16'h0000, s_reg.arg}, s_reg.w_data, s_reg.w_strb));
        scsi_cfg_pkg::OFF_FMT_MOD: s_next.fmt_mod = merge(s_reg.fmt_mod, s_reg.w_data, s_reg.w_strb);
        scsi_cfg_pkg::OFF_FMT_ADDR: s_next.fmt_addr = merge(s_reg.fmt_addr, s_reg.w_data, s_reg.w_strb);
        scsi_cfg_pkg::OFF_FMT_COUNT: s_next.fmt_count = merge(s_reg.fmt_count, s_reg.w_data, s_reg.w_strb);
        scsi_cfg_pkg::OFF_IRQ_MASK: s_next.irq_mask = 3'(merge({29'h0, s_reg.irq_mask}, s_reg.w_data, s_reg.w_strb));
        scsi_cfg_pkg::OFF_INQ_SRC: s_next.inq_src = merge(s_reg.inq_src, s_reg.w_data, s_reg.w_strb);
        default: ;
      endcase
    end
    // command execution on every write to the command register
    if (exec)
    begin
      s_next.cmd = wd[11:0];
      s_next.res_dev = cdev;
      s_next.res_status = scsi_cfg_pkg::ST_IMM_DONE;
      s_next.res_err = scsi_cfg_pkg::ERR_NONE;
      s_next.armed = 1'b0;
      unique case (op)
        scsi_cfg_pkg::OP_PACING:
        begin
          if (cdev != scsi_cfg_pkg::ADAPTER_DEV)
          begin
            s_next.res_status = scsi_cfg_pkg::ST_CMD_ERROR;
            s_next.res_err = scsi_cfg_pkg::ERR_BAD_DEV;
          end
          else if (s_reg.arg[7:0] < {1'b0, scsi_cfg_pkg::PACE_MIN} || s_reg.arg[7:0] > {1'b0, scsi_cfg_pkg::PACE_FULL})
          begin
            s_next.res_status = scsi_cfg_pkg::ST_CMD_ERROR;
            s_next.res_err = scsi_cfg_pkg::ERR_BAD_PARAM;
          end
          else
            s_next.pace = s_reg.arg[6:0];
        end
        scsi_cfg_pkg::OP_FEATURE:
        begin
          if (cdev == scsi_cfg_pkg::ADAPTER_DEV)
          begin
            s_next.rate = s_reg.arg[scsi_cfg_pkg::ARG_RATE_LSB +: 3];
            for (int i = 0; i < scsi_cfg_pkg::NDEV; i++)
              s_next.lim[i] = s_reg.arg[12:0];
          end
          else
            s_next.lim[cdev] = s_reg.arg[12:0];
        end
        scsi_cfg_pkg::OP_FMT_PREP:
        begin
          if (s_reg.arg == scsi_cfg_pkg::PREP_KEY && cdev != scsi_cfg_pkg::ADAPTER_DEV)
          begin
            s_next.armed = 1'b1;
            s_next.prep_dev = cdev;
          end
          else
          begin
            s_next.res_status = scsi_cfg_pkg::ST_CMD_ERROR;
            s_next.res_err = scsi_cfg_pkg::ERR_BAD_PARAM;
          end
        end
        scsi_cfg_pkg::OP_FMT_UNIT:
        begin
          if (!s_reg.armed || s_reg.prep_dev != cdev)
          begin
            s_next.res_status = scsi_cfg_pkg::ST_FAILED;
            s_next.res_err = scsi_cfg_pkg::ERR_FMT_SEQ;
          end
          // block-format list: header plus whole four-byte descriptors
          else if (s_reg.fmt_mod[scsi_cfg_pkg::MOD_DEFECT_BIT]
                   && (s_reg.fmt_count < 32'h0000_0004 || s_reg.fmt_count[1:0] != 2'h0))
          begin
            s_next.res_status = scsi_cfg_pkg::ST_CMD_ERROR;
            s_next.res_err = scsi_cfg_pkg::ERR_BAD_PARAM;
          end
          else
          begin
            s_next.res_status = scsi_cfg_pkg::ST_SUCCESS;
            s_next.fmt.start = 1'b1;
            s_next.fmt.dev = cdev;
            s_next.fmt.interleave = s_reg.fmt_mod[scsi_cfg_pkg::MOD_ILV_LSB +: 16];
            s_next.fmt.list_fetch = s_reg.fmt_mod[scsi_cfg_pkg::MOD_DEFECT_BIT];
            s_next.fmt.list_addr = s_reg.fmt_addr;
            s_next.fmt.list_len = s_reg.fmt_count;
            s_next.fmt.replace_defect_list = s_reg.fmt_mod[scsi_cfg_pkg::MOD_REPLACE_BIT];
            s_next.fmt.background_format_flag = s_reg.fmt_mod[scsi_cfg_pkg::MOD_BACKGROUND_BIT];
            s_next.flush.valid = 1'b1;
            s_next.flush.dev = cdev;
          end
        end
        default:
        begin
          s_next.res_status = scsi_cfg_pkg::ST_CMD_ERROR;
          s_next.res_err = scsi_cfg_pkg::ERR_UNSUPPORTED;
        end
      endcase
      exec_ok = (s_next.res_err == scsi_cfg_pkg::ERR_NONE);
      ev[scsi_cfg_pkg::IRQ_DONE_BIT] = exec_ok;
      ev[scsi_cfg_pkg::IRQ_ERR_BIT] = !exec_ok;
    end
    // seconds prescaler and per-device command timers
    s_next.presc = tick ? 25'h0 : s_reg.presc + 25'h1;
    for (int i = 0; i < scsi_cfg_pkg::NDEV; i++)
    begin
      zero_lim[i] = (s_reg.lim[i] == 13'h0000);
      if (!dev_busy[i])
        s_next.cnt[i] = 13'h0000;
      // saturating at the limit keeps one expiry per command
      else if (tick && !zero_lim[i] && s_reg.cnt[i] < s_reg.lim[i])
      begin
        s_next.cnt[i] = s_reg.cnt[i] + 13'h0001;
        s_next.expire[i] = (s_reg.cnt[i] + 13'h0001 == s_reg.lim[i]);
      end
    end
    ev[scsi_cfg_pkg::IRQ_TMO_BIT] = |s_next.expire;
    // sticky status, write one to clear, a new event wins
    if (wr_do && {s_reg.aw_addr[7:2], 2'b00} == scsi_cfg_pkg::OFF_IRQ_STAT)
      s_next.irq_stat = s_reg.irq_stat & ~wd[2:0];
    s_next.irq_stat = s_next.irq_stat | ev;
    // pacing: credit accumulator grants pace percent of cycles
    if (s_reg.pace_acc + {1'b0, s_reg.pace} >= scsi_cfg_pkg::PACE_ACC_FULL)
    begin
      s_next.pace_acc = s_reg.pace_acc + {1'b0, s_reg.pace} - scsi_cfg_pkg::PACE_ACC_FULL;
      s_next.dma_slot = 1'b1;
    end
    else
    begin
      s_next.pace_acc = s_reg.pace_acc + {1'b0, s_reg.pace};
      s_next.dma_slot = 1'b0;
    end
    // bus read side
    rd_hit = 1'b1;
    unique case ({araddr[7:2], 2'b00})
      scsi_cfg_pkg::OFF_CMD: rd_val = {20'h00000, s_reg.cmd};
      scsi_cfg_pkg::OFF_ARG: rd_val = {16'h0000, s_reg.arg};
      scsi_cfg_pkg::OFF_FMT_MOD: rd_val = s_reg.fmt_mod;
      scsi_cfg_pkg::OFF_FMT_ADDR: rd_val = s_reg.fmt_addr;
      scsi_cfg_pkg::OFF_FMT_COUNT: rd_val = s_reg.fmt_count;
      scsi_cfg_pkg::OFF_RESULT: rd_val = {16'h0000, s_reg.res_dev, s_reg.res_status, s_reg.res_err};
      scsi_cfg_pkg::OFF_IRQ_STAT: rd_val = {29'h0, s_reg.irq_stat};
      scsi_cfg_pkg::OFF_IRQ_MASK: rd_val = {29'h0, s_reg.irq_mask};
      scsi_cfg_pkg::OFF_PACE: rd_val = {21'h0, s_reg.rate, 1'b0, s_reg.pace};
      scsi_cfg_pkg::OFF_INQ_SRC: rd_val = s_reg.inq_src;
      scsi_cfg_pkg::OFF_INQ_HDR0: rd_val = {8'h00, s_reg.inq_src[23:0]};
      scsi_cfg_pkg::OFF_INQ_HDR1: rd_val = {24'h000000, inq_len};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && !s_reg.rvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_val;
      s_next.rresp = rd_hit ? scsi_cfg_pkg::RESP_OKAY : scsi_cfg_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= RST_STATE;
    else if (ce)
      s_reg <= s_next;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign awready = ce && !s_reg.aw_held;
  assign wready = ce && !s_reg.w_held;
  assign arready = ce && !s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = scsi_cfg_pkg::RESP_OKAY;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
  assign cmd_expire = s_reg.expire;
  assign pace_pct = s_reg.pace;
  assign dma_slot_en = s_reg.dma_slot;
  assign rate_sel = s_reg.rate;
  assign fmt_req = s_reg.fmt;
  assign cache_flush = s_reg.flush;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking dcb @(posedge clk iff ce);
  endclocking
  default disable iff (!rst_n);

  logic pace_seen;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pace_seen <= 1'b0;
    else if (ce && exec && op == scsi_cfg_pkg::OP_PACING)
      pace_seen <= 1'b1;
  end

  // last executed command was a good prepare, kept apart from the armed flag
  logic prep_good;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prep_good <= 1'b0;
    else if (ce && exec)
      prep_good <= exec_ok && op == scsi_cfg_pkg::OP_FMT_PREP;
  end

  sequence seq_unit_unarmed;
    !s_reg.armed ##0 (exec && op == scsi_cfg_pkg::OP_FMT_UNIT);
  endsequence
  sequence seq_prep_then_unit;
    prep_good ##0 (exec && op == scsi_cfg_pkg::OP_FMT_UNIT
      && cdev == s_reg.prep_dev && !s_reg.fmt_mod[scsi_cfg_pkg::MOD_DEFECT_BIT]);
  endsequence

  AST_INQ_LEN: assert property (inq_len + scsi_cfg_pkg::INQ_FIXED_LEN == s_reg.inq_src[31:24])
    else $error("inquiry length byte not N-4");
  AST_PACE_RANGE: assert property (pace_pct >= scsi_cfg_pkg::PACE_MIN && pace_pct <= scsi_cfg_pkg::PACE_FULL)
    else $error("pacing outside 25..100");
  AST_PACE_HOLD: assert property (!$stable(pace_pct) |-> $past(exec && op == scsi_cfg_pkg::OP_PACING))
    else $error("pacing changed without a pacing command");
  // slot flag is registered, so it trails the pacing value by one cycle
  AST_PACE_RESET: assert property (!pace_seen |-> (pace_pct == scsi_cfg_pkg::PACE_FULL) ##1 dma_slot_en)
    else $error("pacing not full before first pacing command");
  AST_RATE_DEV: assert property (exec && op == scsi_cfg_pkg::OP_FEATURE && cdev != scsi_cfg_pkg::ADAPTER_DEV
      |=> $stable(rate_sel))
    else $error("per-device feature changed rate");
  AST_FEATURE_ALL: assert property (exec && op == scsi_cfg_pkg::OP_FEATURE && cdev == scsi_cfg_pkg::ADAPTER_DEV
      |=> s_reg.lim[0] == $past(s_reg.arg[12:0]) && s_reg.lim[14] == $past(s_reg.arg[12:0]))
    else $error("adapter feature did not reach all devices");
  AST_FMT_REJECT: assert property (seq_unit_unarmed |=> !fmt_req.start && s_reg.res_err == scsi_cfg_pkg::ERR_FMT_SEQ)
    else $error("format ran without prepare");
  AST_FMT_ACCEPT: assert property (seq_prep_then_unit |=> fmt_req.start)
    else $error("prepared format did not start");
  AST_FLUSH_FMT: assert property (fmt_req.start |-> cache_flush.valid && cache_flush.dev == fmt_req.dev)
    else $error("format without cache flush");
  AST_ZERO_LIMIT: assert property (!(|(cmd_expire & $past(zero_lim))))
    else $error("expiry with zero limit");
  AST_EXPIRE_BUSY: assert property (!(|(cmd_expire & ~$past(dev_busy))))
    else $error("expiry on an idle device");

endmodule : scsi_cfg_cmd

`default_nettype wire

// File: scsi_cfg_pkg.sv
/*
  Shared constants and carriers for the adapter configuration and format
  command block: register byte offsets, command codes, status and error
  codes, reset values, timing counts and the format request carriers.
  Assumes a single 20 MHz adapter clock.
*/
`default_nettype none

package scsi_cfg_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TMO_UNIT_S = 1;
  localparam int unsigned SEC_CYCLES = TMO_UNIT_S * CLK_HZ;
  localparam int unsigned PRESC_W = 25;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ARG = 8'h04;
  localparam logic [7:0] OFF_FMT_MOD = 8'h08;
  localparam logic [7:0] OFF_FMT_ADDR = 8'h0C;
  localparam logic [7:0] OFF_FMT_COUNT = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_PACE = 8'h20;
  localparam logic [7:0] OFF_INQ_SRC = 8'h24;
  localparam logic [7:0] OFF_INQ_HDR0 = 8'h28;
  localparam logic [7:0] OFF_INQ_HDR1 = 8'h2C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CMD_DEV_LSB = 8;
  localparam int MOD_DEFECT_BIT = 0;
  localparam int MOD_REPLACE_BIT = 1;
  localparam int MOD_BACKGROUND_BIT = 2;
  localparam int MOD_ILV_LSB = 16;
  localparam int PACE_RATE_LSB = 8;
  localparam int ARG_RATE_LSB = 13;
  localparam int RES_STATUS_LSB = 8;
  localparam int RES_DEV_LSB = 12;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_TMO_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int TMO_W = 13;
  localparam int NDEV = 15;

  // ----------------------------------------------------------------------
  // command codes and values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_PACING = 8'h0D;
  localparam logic [7:0] OP_FEATURE = 8'h0C;
  localparam logic [7:0] OP_FMT_PREP = 8'h17;
  localparam logic [7:0] OP_FMT_UNIT = 8'h16;
  localparam logic [3:0] ADAPTER_DEV = 4'hF;
  localparam logic [15:0] PREP_KEY = 16'h55AA;
  localparam logic [6:0] PACE_MIN = 7'h19;
  localparam logic [6:0] PACE_FULL = 7'h64;
  localparam logic [7:0] PACE_ACC_FULL = 8'h64;
  localparam logic [12:0] TMO_DEFAULT = 13'h002D;
  localparam logic [2:0] RATE_DEFAULT = 3'h0;
  localparam logic [7:0] INQ_FIXED_LEN = 8'h04;

  localparam logic [3:0] ST_SUCCESS = 4'h1;
  localparam logic [3:0] ST_IMM_DONE = 4'hA;
  localparam logic [3:0] ST_FAILED = 4'hC;
  localparam logic [3:0] ST_CMD_ERROR = 4'hE;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_PARAM = 8'h01;
  localparam logic [7:0] ERR_UNSUPPORTED = 8'h03;
  localparam logic [7:0] ERR_FMT_SEQ = 8'h07;
  localparam logic [7:0] ERR_BAD_DEV = 8'h13;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic [3:0] dev;
    logic [15:0] interleave;
    logic list_fetch;
    logic [31:0] list_addr;
    logic [31:0] list_len;
    logic replace_defect_list;
    logic background_format_flag;
  } fmt_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] dev;
  } cache_flush_t;

endpackage : scsi_cfg_pkg

`default_nettype wire

// File: scsi_target_model.sv
/*
  far-side SCSI target model: busy requests become dev_busy, format requests are latched.
  assumes the adapter clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module scsi_target_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [14:0] busy_req,
  input wire scsi_cfg_pkg::fmt_req_t fmt_req,
  input wire scsi_cfg_pkg::cache_flush_t cache_flush,
  output logic [14:0] dev_busy,
  output scsi_cfg_pkg::fmt_req_t fmt_seen,
  output logic [3:0] flush_dev,
  output int n_fmt
);
  logic [14:0] bg_busy;
  // background format keeps its device busy until reset, since bg_busy never clears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_busy <= '0;
      bg_busy <= '0;
      fmt_seen <= '0;
      flush_dev <= 4'h0;
      n_fmt <= 0;
    end
    else
    begin
      dev_busy <= busy_req | bg_busy;
      if (cache_flush.valid)
        flush_dev <= cache_flush.dev;
      if (fmt_req.start)
      begin
        fmt_seen <= fmt_req;
        n_fmt <= n_fmt + 1;
        if (fmt_req.background_format_flag && fmt_req.dev != 4'hF)
          bg_busy[fmt_req.dev] <= 1'b1;
      end
    end
  end
endmodule : scsi_target_model
`default_nettype wire

// File: scsi_adapter_config_format_commands_bench.sv
/*
  self-checking bench for the configuration and format command block.
  assumes a short seconds prescaler (SEC_CYCLES 10).
*/
`timescale 1ns/100ps
`default_nettype none
module scsi_adapter_config_format_commands_bench;
  typedef struct packed {logic [31:0] arg; logic [15:0] cmd; logic [15:0] res;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [14:0] busy_req = 15'h0, dev_busy, cmd_expire;
  logic awready, wready, bvalid, arready, rvalid, irq, dma_slot_en;
  logic [1:0] bresp, rresp, rd_r;
  logic [6:0] pace_pct;
  logic [2:0] rate_sel;
  logic [3:0] flush_dev;
  scsi_cfg_pkg::fmt_req_t fmt_req, fmt_seen;
  scsi_cfg_pkg::cache_flush_t cache_flush;
  int n_fmt, n_errors = 0, checks_done = 0, e1 = 0, e2 = 0, n;
  row_t rows [10] = '{'{32'h19, 16'hF0D, 16'hFA00}, '{32'h18, 16'hF0D, 16'hFE01},
    '{32'h65, 16'hF0D, 16'hFE01}, '{32'h32, 16'h30D, 16'h3E13}, '{32'hA003, 16'hF0C, 16'hFA00},
    '{32'hE000, 16'h20C, 16'h2A00}, '{32'h0, 16'hF7E, 16'hFE03}, '{32'h0, 16'h416, 16'h4C07},
    '{32'h1234, 16'h417, 16'h4E01}, '{32'h0, 16'h416, 16'h4C07}};
  always #25 clk = ~clk;
  scsi_cfg_cmd #(.SEC_CYCLES(10)) u_scsi_cfg_cmd (.clk, .rst_n, .ce(1'b1), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .irq, .dev_busy, .cmd_expire, .pace_pct,
    .dma_slot_en, .rate_sel, .fmt_req, .cache_flush);
  scsi_target_model u_scsi_target_model (.clk, .rst_n, .busy_req, .fmt_req, .cache_flush, .dev_busy,
    .fmt_seen, .flush_dev, .n_fmt);
  always @(posedge clk)
  begin
    if (cmd_expire[1]) e1++;
    if (cmd_expire[2]) e2++;
  end
  task automatic give_verdict;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      k = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
        @(posedge clk);
        k++;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      while (!bvalid && k < 50);
      if (!bvalid) n_errors++;
      chk("bresp", bresp, 32'h0);
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    begin
      k = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
        @(posedge clk);
        k++;
        if (arready) arvalid <= 1'b0;
      end
      while (!rvalid && k < 50);
      rd_d = rdata;
      rd_r = rresp;
      if (!rvalid) n_errors++;
    end
  endtask : rd
  task automatic cmd(input logic [31:0] arg, input logic [15:0] c);
    begin
      wr(scsi_cfg_pkg::OFF_ARG, arg);
      wr(scsi_cfg_pkg::OFF_CMD, {16'h0, c});
      rd(scsi_cfg_pkg::OFF_RESULT);
    end
  endtask : cmd
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk("pace", pace_pct, 32'h64);
    chk("rate", rate_sel, 32'h0);
    busy_req <= 15'h0001;
    n = 0;
    while (!cmd_expire[0] && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    chk("tmo45", n >= 435 && n <= 465, 32'h1);
    busy_req <= 15'h0;
    wr(scsi_cfg_pkg::OFF_IRQ_MASK, 32'h0);
    foreach (rows[i])
    begin
      cmd(rows[i].arg, rows[i].cmd);
      chk("result", rd_d[15:0], rows[i].res);
    end
    chk("pace", pace_pct, 32'h19);
    chk("rate", rate_sel, 32'h5);
    n = 0;
    repeat (100)
    begin
      @(posedge clk);
      if (dma_slot_en) n++;
    end
    chk("slots", n, 32'd25);
    // masked error leaves irq low, unmasked raises it, w1c drops it
    rd(scsi_cfg_pkg::OFF_IRQ_STAT);
    chk("stat", rd_d[1], 32'h1);
    chk("irq", irq, 32'h0);
    wr(scsi_cfg_pkg::OFF_IRQ_MASK, 32'h2);
    chk("irq", irq, 32'h1);
    wr(scsi_cfg_pkg::OFF_IRQ_STAT, 32'h2);
    chk("irq", irq, 32'h0);
    wr(scsi_cfg_pkg::OFF_INQ_SRC, 32'h2405_8001);
    rd(scsi_cfg_pkg::OFF_INQ_HDR0);
    chk("inq0", rd_d, 32'h0005_8001);
    rd(scsi_cfg_pkg::OFF_INQ_HDR1);
    chk("inq4", rd_d[7:0], 32'h20);
    busy_req <= 15'h0006;
    repeat (60) @(posedge clk);
    chk("exp1", e1, 32'h1);
    chk("exp2", e2, 32'h0);
    busy_req <= 15'h0;
    wr(scsi_cfg_pkg::OFF_FMT_MOD, 32'h0001_0007);
    wr(scsi_cfg_pkg::OFF_FMT_ADDR, 32'h0000_1000);
    wr(scsi_cfg_pkg::OFF_FMT_COUNT, 32'h8);
    cmd(32'h55AA, 16'h417);
    cmd(32'h0, 16'h416);
    chk("fmt", rd_d[15:0], 32'h4100);
    chk("req", {fmt_seen.dev, fmt_seen.interleave, fmt_seen.list_fetch, fmt_seen.replace_defect_list,
      fmt_seen.background_format_flag}, {4'h4, 16'h1, 3'h7});
    chk("addr", fmt_seen.list_addr, 32'h1000);
    chk("len", fmt_seen.list_len, 32'h8);
    chk("flush", flush_dev, 32'h4);
    cmd(32'h55AA, 16'h417);
    cmd(32'h64, 16'hF0D);
    cmd(32'h0, 16'h416);
    chk("seq", rd_d[15:0], 32'h4C07);
    wr(scsi_cfg_pkg::OFF_FMT_COUNT, 32'h6);
    cmd(32'h55AA, 16'h417);
    cmd(32'h0, 16'h416);
    chk("list", rd_d[15:0], 32'h4E01);
    chk("nfmt", n_fmt, 32'h1);
    rd(8'h40);
    chk("resp", rd_r, 32'h2);
    give_verdict();
  end
  // hang guard, far beyond the several hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : scsi_adapter_config_format_commands_bench
`default_nettype wire
